// ---- rtl/operand_decode_pkg.sv ----
// Shared types and constants of the operand field decoder
package operand_decode_pkg;

	// ****************************************
	// Timing and reset values
	// ****************************************
	localparam int OSC_PERIODS_PER_CYCLE = 4;
	localparam logic [1:0] PHASE_LAST = 2'(OSC_PERIODS_PER_CYCLE - 1);
	localparam logic [1:0] PHASE_RESET = 2'h0;
	localparam logic [7:0] ACCUMULATOR_RESET = 8'h00;
	localparam logic [3:0] BANK_RESET = 4'h0;
	localparam logic [20:0] POINTER_RESET = 21'h00_0000;
	localparam logic [20:0] POINTER_STEP = 21'h00_0001;
	localparam logic [7:0] BYTE_RESET = 8'h00;

	// ****************************************
	// Field positions and marks
	// ****************************************
	localparam logic [3:0] SECOND_WORD_MARK = 4'hf;
	localparam int MARK_MSB = 15;
	localparam int MARK_LSB = 12;
	localparam int DEST_BIT = 9;
	localparam int ACCESS_BIT = 8;
	localparam int BIT_INDEX_MSB = 11;
	localparam int BIT_INDEX_LSB = 9;
	localparam int CALL_FAST_BIT = 8;
	localparam int RETURN_FAST_BIT = 0;
	localparam int TABLE_WRITE_BIT = 2;
	localparam int POINTER_SEL_MSB = 5;
	localparam int POINTER_SEL_LSB = 4;
	localparam logic [7:0] ACCESS_SPLIT = 8'h80;
	localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
	localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [3:0] {
		fmt_byte, fmt_bit, fmt_literal8, fmt_pointer_load, fmt_move, fmt_move_indexed,
		fmt_branch_long, fmt_branch_short, fmt_jump, fmt_call, fmt_return, fmt_table, fmt_plain
	} format_type;

	typedef enum logic [1:0] {mode_none, mode_post_inc, mode_post_dec, mode_pre_inc} pointer_update_mode_type;

	typedef enum logic [1:0] {lit_none, lit_8, lit_12, lit_20} literal_width_type;

	typedef struct packed {
		logic carry;
		logic digit_carry_flag;
		logic zero;
		logic overflow_flag;
		logic negative;
	} status_type;

	typedef struct packed {
		format_type format;
		logic nop;
		logic [11:0] data_address;
		logic write_accumulator;
		logic write_file;
		logic [2:0] bit_index;
		logic [7:0] bit_mask;
		logic [1:0] pointer_select;
		logic [11:0] move_source;
		logic [11:0] move_dest;
		logic [19:0] literal;
		literal_width_type literal_width;
		logic [20:0] branch_target;
		logic branch_relative;
		logic fast_mode;
		pointer_update_mode_type pointer_update_mode;
		logic table_write;
		logic [20:0] table_address;
	} fields_type;

endpackage : operand_decode_pkg

// ---- rtl/operand_field_decoder.sv ----
// Operand field decoder between instruction fetch and the execution datapath
`timescale 1ns/1ns
// What this block does
// - Access bit clear uses fixed access region
// - Access bit set uses bank select register
// - Destination clear writes working accumulator only
// - Destination set writes addressed file register
// - Three-bit index picks bit zero to seven
// - File field: byte address or pointer selector
// - Move carries twelve-bit source and destination
// - Literal extracted at eight, twelve, twenty bits
// - Table mode picks one of four updates
// - Branch field relative offset or direct address
// - Fast bit saves or restores shadow copies
// - 21-bit program pointer, 8-bit read latch
// - Don't-care instruction bits never change result
// - Indexed addressing adds seven-bit offsets
// - Five arithmetic status flags are kept
// - Product held in high and low registers
// - Lone second word executes as no-operation
// - Cycle is four clocks; flush inserts no-op
module operand_field_decoder
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Instruction fetch
	input wire logic [15:0] instr_word,
	input wire operand_decode_pkg::format_type instr_format,
	input wire logic instr_valid,
	output logic instr_ready,
	input wire logic flush_req,
	input wire logic [20:0] pc_next,
	input wire logic [11:0] indirect_pointer_value,
	// Decoded fields
	output operand_decode_pkg::fields_type fields,
	output logic fields_valid,
	// Execution results
	input wire logic result_valid,
	input wire logic [7:0] result_data,
	input wire operand_decode_pkg::status_type flags_in,
	input wire operand_decode_pkg::status_type flags_mask,
	input wire logic bank_load_valid,
	input wire logic [3:0] bank_load_value,
	input wire logic mul_valid,
	input wire logic [15:0] mul_product,
	// Table access data
	input wire logic table_read_valid,
	input wire logic [7:0] table_read_data,
	input wire logic latch_load_valid,
	input wire logic [7:0] latch_load_data,
	// Core state
	output logic [7:0] working_accumulator,
	output logic [3:0] bank_select_register,
	output operand_decode_pkg::status_type status,
	output logic [7:0] multiply_result_high,
	output logic [7:0] multiply_result_low,
	output logic [20:0] program_memory_pointer,
	output logic [7:0] program_read_latch,
	// File register write port
	output logic file_write_en,
	output logic [11:0] file_write_addr,
	output logic [7:0] file_write_data
);
	import operand_decode_pkg::*;

	// ****************************************
	// Helpers
	// ****************************************
	// Forms a data address from access bit, file byte and bank
	function automatic logic [11:0] data_addr(input logic acc, input logic [7:0] f, input logic [3:0] bank);
		logic [11:0] r;
		r = 12'h000;
		if (acc)
			r = {bank, f};
		else if (f < ACCESS_SPLIT)
			r = {ACCESS_LOW_BANK, f};
		else
			r = {ACCESS_HIGH_BANK, f};
		return r;
	endfunction : data_addr

	// Relative target from an eleven-bit word offset
	function automatic logic [20:0] rel_target(input logic [20:0] pc, input logic [10:0] n);
		logic [20:0] s;
		s = {{10{n[10]}}, n};
		return pc + {s[19:0], 1'b0};
	endfunction : rel_target

	// ****************************************
	// State
	// ****************************************
	logic [1:0] phase_q;
	logic cycle_en;
	logic take;
	logic pending_q;
	format_type pend_format_q;
	logic [15:0] first_word_q;
	logic start_pending;
	fields_type fields_d;
	fields_type fields_q;
	logic fields_valid_q;
	logic [7:0] accumulator_q;
	logic [3:0] bank_q;
	status_type status_q;
	logic [7:0] prod_high_q;
	logic [7:0] prod_low_q;
	logic [20:0] pointer_q;
	logic [20:0] pointer_d;
	logic [7:0] latch_q;
	logic [7:0] shadow_acc_q;
	logic [3:0] shadow_bank_q;
	status_type shadow_status_q;
	logic shadow_save;
	logic shadow_restore;
	logic file_wr_en_q;
	logic [11:0] file_wr_addr_q;
	logic [7:0] file_wr_data_q;

	// ****************************************
	// Instruction cycle timing
	// ****************************************
	// four clocks per instruction cycle
	always_ff @(posedge mclk)
	begin
		if (rst)
			phase_q <= PHASE_RESET;
		else
			phase_q <= phase_q + 2'h1;
	end

	assign cycle_en = (phase_q == PHASE_LAST);
	assign instr_ready = cycle_en;
	assign take = cycle_en && instr_valid;

	// ****************************************
	// Field extraction
	// ****************************************
	// Builds the fields of the word taken this cycle
	always_comb
	begin
		fields_d = '0;
		fields_d.format = pending_q ? pend_format_q : instr_format;
		fields_d.table_address = pointer_q;
		pointer_d = pointer_q;
		start_pending = 1'b0;
		if (flush_req)
			fields_d.nop = 1'b1;
		else if (pending_q)
		begin
			// Second word completes a two-word instruction
			case (pend_format_q)
				fmt_move:
				begin
					fields_d.move_source = first_word_q[11:0];
					fields_d.move_dest = instr_word[11:0];
				end
				// offsets added to the indirect pointer
				fmt_move_indexed:
				begin
					fields_d.move_source = indirect_pointer_value + {5'h00, first_word_q[6:0]};
					fields_d.move_dest = indirect_pointer_value + {5'h00, instr_word[6:0]};
				end
				fmt_pointer_load:
				begin
					fields_d.pointer_select = first_word_q[POINTER_SEL_MSB:POINTER_SEL_LSB];
					fields_d.literal = {8'h00, first_word_q[3:0], instr_word[7:0]};
					fields_d.literal_width = lit_12;
				end
				// direct address for jump and call
				fmt_jump, fmt_call:
				begin
					fields_d.literal = {instr_word[11:0], first_word_q[7:0]};
					fields_d.literal_width = lit_20;
					fields_d.branch_target = {instr_word[11:0], first_word_q[7:0], 1'b0};
					fields_d.fast_mode = (pend_format_q == fmt_call) && first_word_q[CALL_FAST_BIT];
				end
				default:
					fields_d.nop = 1'b1;
			endcase
		end
		// second word alone is a no-op
		else if (instr_word[MARK_MSB:MARK_LSB] == SECOND_WORD_MARK)
			fields_d.nop = 1'b1;
		else
		begin
			// only defined bits of each format are read
			case (instr_format)
				fmt_byte:
				begin
					fields_d.data_address = data_addr(instr_word[ACCESS_BIT], instr_word[7:0], bank_q);
					fields_d.write_accumulator = !instr_word[DEST_BIT];
					fields_d.write_file = instr_word[DEST_BIT];
				end
				fmt_bit:
				begin
					fields_d.data_address = data_addr(instr_word[ACCESS_BIT], instr_word[7:0], bank_q);
					fields_d.bit_index = instr_word[BIT_INDEX_MSB:BIT_INDEX_LSB];
					fields_d.bit_mask = 8'h01 << instr_word[BIT_INDEX_MSB:BIT_INDEX_LSB];
					fields_d.write_file = 1'b1;
				end
				fmt_literal8:
				begin
					fields_d.literal = {12'h000, instr_word[7:0]};
					fields_d.literal_width = lit_8;
				end
				fmt_move, fmt_move_indexed, fmt_pointer_load, fmt_jump, fmt_call:
					start_pending = 1'b1;
				fmt_branch_long:
				begin
					fields_d.branch_target = rel_target(pc_next, instr_word[10:0]);
					fields_d.branch_relative = 1'b1;
				end
				fmt_branch_short:
				begin
					fields_d.branch_target = rel_target(pc_next, {{3{instr_word[7]}}, instr_word[7:0]});
					fields_d.branch_relative = 1'b1;
				end
				fmt_return:
					fields_d.fast_mode = instr_word[RETURN_FAST_BIT];
				fmt_table:
				begin
					fields_d.pointer_update_mode = pointer_update_mode_type'(instr_word[1:0]);
					fields_d.table_write = instr_word[TABLE_WRITE_BIT];
					case (fields_d.pointer_update_mode)
						mode_post_inc:
							pointer_d = pointer_q + POINTER_STEP;
						mode_post_dec:
							pointer_d = pointer_q - POINTER_STEP;
						mode_pre_inc:
						begin
							pointer_d = pointer_q + POINTER_STEP;
							fields_d.table_address = pointer_q + POINTER_STEP;
						end
						default:
							pointer_d = pointer_q;
					endcase
				end
				default:
					fields_d.nop = 1'b0;
			endcase
		end
	end

	// ****************************************
	// Two-word tracking
	// ****************************************
	// Holds the first word until its partner arrives
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			pending_q <= 1'b0;
			pend_format_q <= fmt_plain;
			first_word_q <= 16'h0000;
		end
		else if (take)
		begin
			pending_q <= start_pending && !flush_req;
			pend_format_q <= instr_format;
			first_word_q <= instr_word;
		end
	end

	// fields registered at the decoding edge
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			fields_q <= '0;
			fields_valid_q <= 1'b0;
		end
		else if (cycle_en)
		begin
			fields_valid_q <= take && !start_pending;
			if (take)
				fields_q <= fields_d;
		end
	end

	assign fields = fields_q;
	assign fields_valid = fields_valid_q;

	// ****************************************
	// Table pointer and latch
	// ****************************************
	// 21-bit pointer and 8-bit latch
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			pointer_q <= POINTER_RESET;
			latch_q <= BYTE_RESET;
		end
		else
		begin
			if (take)
				pointer_q <= pointer_d;
			if (table_read_valid)
				latch_q <= table_read_data;
			else if (latch_load_valid)
				latch_q <= latch_load_data;
		end
	end

	// ****************************************
	// Results, flags and shadows
	// ****************************************
	assign shadow_save = take && !flush_req && fields_d.fast_mode && pending_q && (pend_format_q == fmt_call);
	assign shadow_restore = take && !flush_req && fields_d.fast_mode && !pending_q && (instr_format == fmt_return);

	// shadow copies change only in fast mode
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			shadow_acc_q <= ACCUMULATOR_RESET;
			shadow_bank_q <= BANK_RESET;
			shadow_status_q <= '0;
		end
		else if (shadow_save)
		begin
			shadow_acc_q <= accumulator_q;
			shadow_bank_q <= bank_q;
			shadow_status_q <= status_q;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			accumulator_q <= ACCUMULATOR_RESET;
			bank_q <= BANK_RESET;
			status_q <= '0;
		end
		else if (shadow_restore)
		begin
			accumulator_q <= shadow_acc_q;
			bank_q <= shadow_bank_q;
			status_q <= shadow_status_q;
		end
		else
		begin
			if (result_valid && fields_q.write_accumulator)
				accumulator_q <= result_data;
			if (bank_load_valid)
				bank_q <= bank_load_value;
			if (result_valid)
				status_q <= (status_q & ~flags_mask) | (flags_in & flags_mask);
		end
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			file_wr_en_q <= 1'b0;
			file_wr_addr_q <= 12'h000;
			file_wr_data_q <= BYTE_RESET;
		end
		else
		begin
			file_wr_en_q <= result_valid && fields_q.write_file;
			file_wr_addr_q <= fields_q.data_address;
			file_wr_data_q <= result_data;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			prod_high_q <= BYTE_RESET;
			prod_low_q <= BYTE_RESET;
		end
		else if (mul_valid)
		begin
			prod_high_q <= mul_product[15:8];
			prod_low_q <= mul_product[7:0];
		end
	end

	// Output drive
	assign working_accumulator = accumulator_q;
	assign bank_select_register = bank_q;
	assign status = status_q;
	assign multiply_result_high = prod_high_q;
	assign multiply_result_low = prod_low_q;
	assign program_memory_pointer = pointer_q;
	assign program_read_latch = latch_q;
	assign file_write_en = file_wr_en_q;
	assign file_write_addr = file_wr_addr_q;
	assign file_write_data = file_wr_data_q;

	// ****************************************
	// Checks
	// ****************************************
	chk_cycle_period: assert property (@(posedge mclk) disable iff (rst)
		cycle_en |=> !cycle_en [*3] ##1 cycle_en) else $error("cycle enable not every four clocks");
	chk_access_region: assert property (@(posedge mclk) disable iff (rst)
		take && !flush_req && !pending_q && instr_format == fmt_byte && !instr_word[ACCESS_BIT]
		&& instr_word[MARK_MSB:MARK_LSB] != SECOND_WORD_MARK
		|=> fields_q.data_address[11:8] == ACCESS_LOW_BANK || fields_q.data_address[11:8] == ACCESS_HIGH_BANK)
		else $error("access address left the access region");
	chk_banked_address: assert property (@(posedge mclk) disable iff (rst)
		take && !flush_req && !pending_q && instr_format == fmt_byte && instr_word[ACCESS_BIT]
		&& instr_word[MARK_MSB:MARK_LSB] != SECOND_WORD_MARK
		|=> fields_q.data_address == {$past(bank_q), $past(instr_word[7:0])}) else $error("banked address wrong");
	chk_dest_accum: assert property (@(posedge mclk) disable iff (rst)
		result_valid && fields_q.write_accumulator && !shadow_restore |=> accumulator_q == $past(result_data)
		&& !file_wr_en_q) else $error("accumulator result not stored");
	chk_dest_file: assert property (@(posedge mclk) disable iff (rst)
		result_valid && fields_q.write_file && !shadow_restore |=> file_wr_en_q && file_write_data == $past(result_data)
		&& $stable(accumulator_q)) else $error("file write back wrong");
	chk_lone_second: assert property (@(posedge mclk) disable iff (rst)
		take && !pending_q && instr_word[MARK_MSB:MARK_LSB] == SECOND_WORD_MARK |=> fields_q.nop && fields_valid_q)
		else $error("lone second word not a no-op");
	chk_post_inc: assert property (@(posedge mclk) disable iff (rst)
		take && !flush_req && !pending_q && instr_format == fmt_table && instr_word[1:0] == 2'h1
		&& instr_word[MARK_MSB:MARK_LSB] != SECOND_WORD_MARK
		|=> pointer_q == $past(pointer_q) + POINTER_STEP && fields_q.table_address == $past(pointer_q))
		else $error("post increment wrong");
	chk_shadow_keep: assert property (@(posedge mclk) disable iff (rst)
		!shadow_save |=> $stable(shadow_acc_q) && $stable(shadow_bank_q)) else $error("shadow changed without fast call");
	cov_two_word: cover property (@(posedge mclk) disable iff (rst) take && start_pending ##4 take && pending_q);
	cov_fast_return: cover property (@(posedge mclk) disable iff (rst) shadow_restore);
	cov_flush: cover property (@(posedge mclk) disable iff (rst) take && flush_req);

endmodule : operand_field_decoder

// ---- sim/file_register_model.sv ----
// File register model standing at the decoder's write port
`timescale 1ns/1ns
module file_register_model
(
	// Clock
	input wire logic mclk,
	// Write port from the decoder
	input wire logic file_write_en,
	input wire logic [11:0] file_write_addr,
	input wire logic [7:0] file_write_data
);
	// ****************************************
	// Storage of the whole data space
	// ****************************************
	logic [7:0] mem_q [0:4095];

	// file register writeback
	// Store one byte per write pulse, twelve-bit address reaches all of it
	always_ff @(posedge mclk)
	begin
		if (file_write_en)
		begin
			mem_q[file_write_addr] <= file_write_data;
		end
	end
endmodule : file_register_model

// ---- sim/test_operand_field_decoder.sv ----
// Self-checking bench of the operand field decoder
`timescale 1ns/1ns
module test_operand_field_decoder;
	import operand_decode_pkg::*;

	// ****************************************
	// Stimulus and observed signals
	// ****************************************
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic [15:0] instr_word = 16'h0000;
	format_type instr_format = fmt_plain;
	logic instr_valid = 1'b0;
	logic instr_ready;
	logic flush_req = 1'b0;
	logic [20:0] pc_next = 21'h00_0100;
	logic [11:0] indirect_pointer_value = 12'h000;
	fields_type fields;
	logic fields_valid;
	logic result_valid = 1'b0;
	logic [7:0] result_data = 8'h00;
	status_type flags_in = 5'h00;
	status_type flags_mask = 5'h00;
	logic bank_load_valid = 1'b0;
	logic [3:0] bank_load_value = 4'h0;
	logic mul_valid = 1'b0;
	logic [15:0] mul_product = 16'h0000;
	logic table_read_valid = 1'b0;
	logic [7:0] table_read_data = 8'h00;
	logic latch_load_valid = 1'b0;
	logic [7:0] latch_load_data = 8'h00;
	logic [7:0] working_accumulator;
	logic [3:0] bank_select_register;
	status_type status;
	logic [7:0] multiply_result_high;
	logic [7:0] multiply_result_low;
	logic [20:0] program_memory_pointer;
	logic [7:0] program_read_latch;
	logic file_write_en;
	logic [11:0] file_write_addr;
	logic [7:0] file_write_data;
	int miscompares = 0;
	int tests_run = 0;

	typedef struct {logic [15:0] word; format_type fmt; int sel; logic [20:0] exp;} row_type;
	row_type rows [17];

	// Clock of 20 ns
	initial
	begin
		forever #10 mclk = ~mclk;
	end

	// ****************************************
	// Design and far side
	// ****************************************
	operand_field_decoder u_dut (.mclk(mclk), .rst(rst), .instr_word(instr_word), .instr_format(instr_format),
		.instr_valid(instr_valid), .instr_ready(instr_ready), .flush_req(flush_req), .pc_next(pc_next),
		.indirect_pointer_value(indirect_pointer_value), .fields(fields), .fields_valid(fields_valid),
		.result_valid(result_valid), .result_data(result_data), .flags_in(flags_in), .flags_mask(flags_mask),
		.bank_load_valid(bank_load_valid), .bank_load_value(bank_load_value), .mul_valid(mul_valid),
		.mul_product(mul_product), .table_read_valid(table_read_valid), .table_read_data(table_read_data),
		.latch_load_valid(latch_load_valid), .latch_load_data(latch_load_data),
		.working_accumulator(working_accumulator), .bank_select_register(bank_select_register), .status(status),
		.multiply_result_high(multiply_result_high), .multiply_result_low(multiply_result_low),
		.program_memory_pointer(program_memory_pointer), .program_read_latch(program_read_latch),
		.file_write_en(file_write_en), .file_write_addr(file_write_addr), .file_write_data(file_write_data));

	file_register_model u_file (.mclk(mclk), .file_write_en(file_write_en), .file_write_addr(file_write_addr),
		.file_write_data(file_write_data));

	// ****************************************
	// Tasks
	// ****************************************
	task automatic final_report();
		$display("tests_run=%0d miscompares=%0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : final_report

	task automatic chk(input logic [20:0] got, input logic [20:0] exp, input string msg);
		tests_run++;
		if (got !== exp)
		begin
			$display("[ERR] %0t %s got %0h expected %0h", $time, msg, got, exp);
			miscompares++;
		end
	endtask : chk

	// Offer a word, wait for the take, return when fields stand
	task automatic issue(input logic [15:0] w, input format_type f, input logic fl);
		int n;
		@(negedge mclk);
		instr_word = w;
		instr_format = f;
		instr_valid = 1'b1;
		flush_req = fl;
		n = 0;
		while (instr_ready !== 1'b1 && n < 8)
		begin
			@(negedge mclk);
			n++;
		end
		if (n >= 8)
		begin
			miscompares++;
			final_report();
		end
		@(negedge mclk);
		instr_valid = 1'b0;
		flush_req = 1'b0;
		@(negedge mclk);
	endtask : issue

	// One result pulse from the datapath
	task automatic result(input logic [7:0] dat);
		@(negedge mclk);
		result_valid = 1'b1;
		result_data = dat;
		@(negedge mclk);
		result_valid = 1'b0;
	endtask : result

	// Field chosen by a row
	function automatic logic [20:0] pick(input int sel);
		case (sel)
			0: pick = 21'(fields.data_address);
			1: pick = 21'({fields.write_accumulator, fields.write_file});
			2: pick = 21'(fields.bit_mask);
			3: pick = 21'(fields.literal);
			4: pick = 21'(fields.fast_mode);
			5: pick = fields.branch_target;
			6: pick = fields.table_address;
			default: pick = 21'(fields.nop);
		endcase
	endfunction : pick

	// ****************************************
	// Main sequence
	// ****************************************
	initial
	begin
		int n;
		rows[0] = '{16'h2412, fmt_byte, 0, 21'h00_0012};
		rows[1] = '{16'h2493, fmt_byte, 0, 21'h00_0f93};
		rows[2] = '{16'h2534, fmt_byte, 0, 21'h00_0534};
		rows[3] = '{16'h2434, fmt_byte, 1, 21'h00_0002};
		rows[4] = '{16'h2634, fmt_byte, 1, 21'h00_0001};
		rows[5] = '{16'h8012, fmt_bit, 2, 21'h00_0001};
		rows[6] = '{16'h8e12, fmt_bit, 2, 21'h00_0080};
		rows[7] = '{16'h0e7f, fmt_literal8, 3, 21'h00_007f};
		rows[8] = '{16'h0013, fmt_return, 4, 21'h00_0001};
		rows[9] = '{16'h0012, fmt_return, 4, 21'h00_0000};
		rows[10] = '{16'he0fe, fmt_branch_short, 5, 21'h00_00fc};
		rows[11] = '{16'hd001, fmt_branch_long, 5, 21'h00_0102};
		rows[12] = '{16'h0009, fmt_table, 6, 21'h00_0000};
		rows[13] = '{16'h000b, fmt_table, 6, 21'h00_0002};
		rows[14] = '{16'h000a, fmt_table, 6, 21'h00_0002};
		rows[15] = '{16'h0008, fmt_table, 6, 21'h00_0001};
		rows[16] = '{16'hf123, fmt_byte, 7, 21'h00_0001};
		repeat (12) @(posedge mclk);
		@(negedge mclk);
		rst = 1'b0;
		chk(fields_valid, 0, "valid after reset");
		chk(program_memory_pointer, 0, "pointer after reset");
		// Bank load, then the slot period
		bank_load_valid = 1'b1;
		bank_load_value = 4'h5;
		@(negedge mclk);
		bank_load_valid = 1'b0;
		chk(bank_select_register, 5, "bank load");
		n = 0;
		while (instr_ready !== 1'b1 && n < 8)
		begin
			@(negedge mclk);
			n++;
		end
		if (n >= 8)
		begin
			miscompares++;
			final_report();
		end
		@(negedge mclk);
		n = 1;
		while (instr_ready !== 1'b1 && n < 9)
		begin
			@(negedge mclk);
			n++;
		end
		chk(21'(n), 4, "cycle period");
		// Table of single-word cases
		foreach (rows[i])
		begin
			issue(rows[i].word, rows[i].fmt, 1'b0);
			chk(pick(rows[i].sel), rows[i].exp, $sformatf("row %0d", i));
		end
		chk(program_memory_pointer, 1, "pointer after modes");
		// Two-word move, jump and pointer load
		issue(16'hc123, fmt_move, 1'b0);
		chk(fields_valid, 0, "first word pends");
		issue(16'hf456, fmt_plain, 1'b0);
		chk(fields.move_source, 12'h123, "move source");
		chk(fields.move_dest, 12'h456, "move dest");
		chk(fields_valid, 1, "move valid");
		issue(16'hef34, fmt_jump, 1'b0);
		issue(16'hf567, fmt_plain, 1'b0);
		chk(fields.branch_target, 21'h0a_ce68, "jump target");
		chk(fields.branch_relative, 0, "jump absolute");
		chk(fields.literal_width, lit_20, "jump literal width");
		issue(16'hee12, fmt_pointer_load, 1'b0);
		issue(16'hf034, fmt_plain, 1'b0);
		chk(fields.pointer_select, 1, "pointer select");
		chk(fields.literal, 20'h0_0234, "twelve-bit literal");
		chk(fields.literal_width, lit_12, "literal width");
		// Indexed move, bit 7 of the first word is a don't-care
		indirect_pointer_value = 12'h200;
		issue(16'he885, fmt_move_indexed, 1'b0);
		issue(16'hf00a, fmt_plain, 1'b0);
		chk(fields.move_source, 12'h205, "indexed source");
		chk(fields.move_dest, 12'h20a, "indexed dest");
		// Table write flag with no pointer change
		issue(16'h0004, fmt_table, 1'b0);
		chk(fields.table_write, 1, "table write");
		chk(program_memory_pointer, 1, "pointer kept");
		// Results to file register and accumulator
		flags_in = 5'h1f;
		flags_mask = 5'h04;
		issue(16'h2634, fmt_byte, 1'b0);
		result(8'ha5);
		chk(file_write_en, 1, "file write");
		chk(file_write_addr, 12'h034, "file address");
		chk(file_write_data, 8'ha5, "file data");
		@(negedge mclk);
		chk(u_file.mem_q[12'h034], 8'ha5, "file stored");
		chk(file_write_en, 0, "write one cycle");
		issue(16'h2434, fmt_byte, 1'b0);
		result(8'h5a);
		chk(working_accumulator, 8'h5a, "accumulator");
		chk(file_write_en, 0, "no file write");
		chk(status, 5'h04, "masked flags");
		// Fast call saves, fast return restores
		issue(16'hed00, fmt_call, 1'b0);
		issue(16'hf000, fmt_plain, 1'b0);
		chk(fields.fast_mode, 1, "fast call");
		flags_mask = 5'h00;
		issue(16'h2434, fmt_byte, 1'b0);
		result(8'h11);
		chk(working_accumulator, 8'h11, "accumulator again");
		issue(16'h0013, fmt_return, 1'b0);
		chk(working_accumulator, 8'h5a, "shadow restore");
		// Product bytes and table latch priority
		@(negedge mclk);
		mul_valid = 1'b1;
		mul_product = 16'hbeef;
		table_read_valid = 1'b1;
		table_read_data = 8'h3c;
		latch_load_valid = 1'b1;
		latch_load_data = 8'h77;
		@(negedge mclk);
		mul_valid = 1'b0;
		table_read_valid = 1'b0;
		latch_load_valid = 1'b0;
		chk(multiply_result_high, 8'hbe, "product high");
		chk(multiply_result_low, 8'hef, "product low");
		chk(program_read_latch, 8'h3c, "table latch");
		// Latch load on its own
		latch_load_valid = 1'b1;
		@(negedge mclk);
		latch_load_valid = 1'b0;
		chk(program_read_latch, 8'h77, "latch load");
		// Flushed word and a second reset
		issue(16'h2412, fmt_byte, 1'b1);
		chk(fields.nop, 1, "flushed word");
		rst = 1'b1;
		repeat (2) @(negedge mclk);
		rst = 1'b0;
		chk(working_accumulator, 0, "accumulator reset");
		chk(fields_valid, 0, "valid reset");
		final_report();
	end
endmodule : test_operand_field_decoder
